// ---- src/osp_regs.svh ----
`ifndef OSP_REGS_SVH
`define OSP_REGS_SVH
// register byte offsets
`define OSP_OSC_CTRL_OFS 12'h000
`define OSP_CLK_DIV_OFS 12'h004
`define OSP_PLL_FBD_OFS 12'h008
`define OSP_UNLOCK_OFS 12'h00c
// oscillator control field positions
`define OSP_CUR_LSB 12
`define OSP_NEXT_LSB 8
`define OSP_BLOCK_BIT 7
`define OSP_PIN_REMAP_BLOCK_BIT 6
`define OSP_LOCK_BIT 5
`define OSP_CF_BIT 3
`define OSP_LPOSC_BIT 1
`define OSP_SWITCH_REQUEST_BIT 0
// divisor field positions and power-on values
`define OSP_POST_LSB 6
`define OSP_POST_RESET 2'h1
`define OSP_PRE_RESET 5'h00
`define OSP_FBD_RESET 9'h030
// postscale codes
`define OSP_POST_DIV2 2'h0
`define OSP_POST_DIV4 2'h1
`define OSP_POST_RSVD 2'h2
// switch monitor config: switching on, monitor off / both on
`define OSP_SWITCH_MONITOR_CFG_SW_ONLY 2'h1
`define OSP_SWITCH_MONITOR_CFG_ALL_ON 2'h0
// timing, in ns
`define OSP_CLK_NS 40
`define OSP_PLL_LOCK_NS 2000
`define OSP_SWITCH_NS 400
`define OSP_UNLOCK_NS 320
`endif

// ---- src/osp_pkg.sv ----
package osp_pkg;
	// clock source codes, shared by current and next fields
	typedef enum logic [2:0] {
		SRC_FRC = 3'h0,
		SRC_FRC_PLL = 3'h1,
		SRC_PRI = 3'h2,
		SRC_PRI_PLL = 3'h3,
		SRC_SEC = 3'h4,
		SRC_LOW_POWER_RC_OSC = 3'h5,
		SRC_FRC_DIV16 = 3'h6,
		SRC_FRC_DIVN = 3'h7
	} osp_src_e;
	// primary submode
	typedef enum logic [1:0] {
		SUB_EC = 2'h0,
		SUB_XT = 2'h1,
		SUB_HS = 2'h2,
		SUB_OFF = 2'h3
	} osp_sub_e;
	// switch sequencer, one-hot
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_SWITCH = 2'b10
	} osp_state_e;
endpackage : osp_pkg

// ---- src/osp_pll_if.sv ----
`timescale 1ns/1ps
interface osp_pll_if;
	logic run; // pll selected and source settled
	logic [19:0] ref_khz; // reference input frequency
	logic [4:0] pre; // prescale field
	logic [1:0] post; // postscale field
	logic [8:0] fbd; // feedback field
	logic [19:0] fosc_khz; // pll output frequency
	logic locked; // lock timer satisfied
	modport ctrl (output run, ref_khz, pre, post, fbd,
		input fosc_khz, locked);
	modport pll (input run, ref_khz, pre, post, fbd,
		output fosc_khz, locked);
endinterface : osp_pll_if

// ---- src/osp_pll.sv ----
`timescale 1ns/1ps
`include "osp_regs.svh"
module osp_pll #(
	parameter int unsigned LOCK_CYC = 50
) (
	input wire logic i_clk,
	input wire logic i_reset,
	osp_pll_if.pll pll
);
	logic [5:0] n1; // prescale factor
	logic [9:0] m; // feedback multiplier
	logic [3:0] n2; // postscale factor
	logic [9:0] div; // n1 times n2
	logic [31:0] prod; // reference times m
	logic [31:0] quo;
	logic [15:0] cnt_q; // lock timer
	logic [15:0] cnt_d;
	logic [19:0] fosc_q;
	logic locked_q;

	assign n1 = {1'b0, pll.pre} + 6'd2;
	assign m = {1'b0, pll.fbd} + 10'd2;
	// reserved code never stored, so it needs no decode
	assign n2 = (pll.post == `OSP_POST_DIV2) ? 4'd2 :
		(pll.post == `OSP_POST_DIV4) ? 4'd4 : 4'd8;
	// operands widened first so the products cannot wrap
	assign div = 10'(n1) * 10'(n2);
	assign prod = 32'(pll.ref_khz) * 32'(m);
	assign quo = prod / {22'h0, div};
	// timer restarts whenever the pll drops out of use
	assign cnt_d = !pll.run ? 16'h0 :
		(cnt_q == 16'(LOCK_CYC)) ? cnt_q : cnt_q + 16'h1;

	// output frequency and lock state
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			cnt_q <= 16'h0;
			fosc_q <= 20'h0;
			locked_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			fosc_q <= quo[19:0];
			locked_q <= (cnt_d == 16'(LOCK_CYC));
		end
	end
	assign pll.fosc_khz = fosc_q;
	assign pll.locked = locked_q;

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	drop_lock_a: assert property (!pll.run |=> !pll.locked)
		else $error("lock flag held without pll");
	lock_wait_a: assert property (
		$rose(pll.run) |=> !pll.locked[*2])
		else $error("pll locked too early");
	// inputs steady over the last edge: output reflects them now
	fosc_eq_a: assert property (
		##1 ($stable(pll.pre) && $stable(pll.fbd) && $stable(pll.post)
		&& $stable(pll.ref_khz)) |-> pll.fosc_khz ==
		20'((32'(pll.ref_khz) * 32'(m)) / {22'h0, div}))
		else $error("pll frequency wrong");
	lock_rise_c: cover property ($rose(pll.locked));
endmodule : osp_pll

// ---- src/osp_ctrl.sv ----
`timescale 1ns/1ps
`include "osp_regs.svh"
module osp_ctrl #(
	parameter logic [15:0] UNLOCK_KEY = 16'h5a5a // arbitrary key
) (
	input wire logic I_REF_CLK,
	input wire logic I_RESET, // power-on reset
	input wire logic I_SYS_RESET, // any other reset
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	output logic [31:0] O_HRDATA,
	input wire logic [2:0] I_INITIAL_SOURCE_CFG,
	input wire logic [1:0] I_PRIMARY_SUBMODE_CFG,
	input wire logic [1:0] I_SWITCH_MONITOR_CFG,
	input wire logic I_CLOCK_FAIL, // pulse from fail-safe monitor
	input wire logic I_PIN_REMAP_WR, // pin remap write attempt
	input wire logic [19:0] I_FRC_KHZ,
	input wire logic [19:0] I_PRIMARY_KHZ,
	input wire logic [19:0] I_SLOW_KHZ, // secondary or low-power rc
	output logic O_PIN_REMAP_WR_EN,
	output logic [2:0] O_CURRENT_SOURCE,
	output logic [1:0] O_PRIMARY_SUBMODE,
	output logic O_SECONDARY_OSC_EN,
	output logic O_PLL_LOCK,
	output logic [19:0] O_FOSC_KHZ,
	output logic [19:0] O_FCY_KHZ
);
	// least times round up, the unlock window rounds down
	localparam int unsigned LOCK_CYC =
		(`OSP_PLL_LOCK_NS + `OSP_CLK_NS - 1) / `OSP_CLK_NS;
	localparam int unsigned SW_CYC =
		(`OSP_SWITCH_NS + `OSP_CLK_NS - 1) / `OSP_CLK_NS;
	localparam int unsigned UNL_CYC = `OSP_UNLOCK_NS / `OSP_CLK_NS;
	localparam int SW_END = SW_CYC + 1; // new source visible one edge on

	osp_pll_if pll_if ();

	// power-on state, survives the system reset
	osp_pkg::osp_src_e cur_q; // source in use
	logic [2:0] next_q; // requested source
	logic block_q; // source change block
	logic pin_remap_block_q; // pin remap block
	logic cf_q; // clock fail flag
	logic lposc_q; // secondary oscillator enable
	logic switch_request_q; // switch request
	logic [1:0] post_q;
	logic [4:0] pre_q;
	logic [8:0] fbd_q;
	logic [1:0] sub_q; // submode caught at power-on
	logic [1:0] switch_monitor_cfg_q; // switch/monitor config caught at power-on
	// sequencer and bus state
	osp_pkg::osp_state_e st_q;
	logic [7:0] sw_cnt_q; // settle count during a switch
	logic [7:0] unl_cnt_q; // unlock window remaining
	logic dp_wr_q; // data phase is a word write
	logic [11:0] dp_addr_q;
	logic [31:0] rdata_q;
	logic [19:0] fosc_q;
	logic [19:0] fcy_q;

	// bus decode
	wire addr_ok = I_HSEL && I_HTRANS[1] && I_HREADY;
	wire word_ok = (I_HSIZE == 3'h2);
	wire [11:0] a_addr = I_HADDR[11:0];
	wire wr_osc = dp_wr_q && (dp_addr_q == `OSP_OSC_CTRL_OFS);
	wire wr_div = dp_wr_q && (dp_addr_q == `OSP_CLK_DIV_OFS);
	wire wr_fbd = dp_wr_q && (dp_addr_q == `OSP_PLL_FBD_OFS);
	wire wr_key = dp_wr_q && (dp_addr_q == `OSP_UNLOCK_OFS);
	wire key_ok = wr_key && (I_HWDATA[15:0] == UNLOCK_KEY);
	wire unlocked = (unl_cnt_q != 8'h0);
	wire osc_wr = wr_osc && unlocked;
	wire [15:0] wd = I_HWDATA[15:0];

	// switch permission from the power-on config
	wire sw_on = !switch_monitor_cfg_q[1];
	wire failsafe_clock_monitor_on = (switch_monitor_cfg_q == `OSP_SWITCH_MONITOR_CFG_ALL_ON);
	wire blocked = block_q && (switch_monitor_cfg_q == `OSP_SWITCH_MONITOR_CFG_SW_ONLY);
	wire sw_start = (st_q == osp_pkg::ST_RUN) && switch_request_q && sw_on
		&& !blocked;
	wire sw_done = (st_q == osp_pkg::ST_SWITCH) && (sw_cnt_q == 8'h0);
	wire cur_pll = (cur_q == osp_pkg::SRC_FRC_PLL) ||
		(cur_q == osp_pkg::SRC_PRI_PLL);
	// lock reads low while not on the pll or mid-switch
	wire lock_rd = pll_if.locked && cur_pll &&
		(st_q == osp_pkg::ST_RUN);

	// read images; unimplemented bits are constant zero
	wire [15:0] osc_img = {1'b0, cur_q, 1'b0, next_q, block_q,
		pin_remap_block_q, lock_rd, 1'b0, cf_q, 1'b0, lposc_q,
		switch_request_q};
	wire [15:0] div_img = {8'h00, post_q, 1'b0, pre_q};
	wire [15:0] fbd_img = {7'h00, fbd_q};
	wire [15:0] rd_mux =
		(a_addr == `OSP_OSC_CTRL_OFS) ? osc_img :
		(a_addr == `OSP_CLK_DIV_OFS) ? div_img :
		(a_addr == `OSP_PLL_FBD_OFS) ? fbd_img : 16'h0000;

	// flag next values: hardware set wins over a software clear
	wire cf_d = (I_CLOCK_FAIL && failsafe_clock_monitor_on) ||
		(cf_q && !(osc_wr && !wd[`OSP_CF_BIT]));
	wire switch_request_d = (osc_wr && wd[`OSP_SWITCH_REQUEST_BIT] && sw_on) ||
		(switch_request_q && !sw_done && sw_on);
	// the reserved postscale code leaves the field as it was
	wire post_keep = (wd[7:6] == `OSP_POST_RSVD);

	// frequency selection by the source in use
	wire [19:0] fosc_d =
		(cur_q == osp_pkg::SRC_FRC_PLL) ? pll_if.fosc_khz :
		(cur_q == osp_pkg::SRC_PRI_PLL) ? pll_if.fosc_khz :
		(cur_q == osp_pkg::SRC_PRI) ? I_PRIMARY_KHZ :
		(cur_q == osp_pkg::SRC_SEC) ? I_SLOW_KHZ :
		(cur_q == osp_pkg::SRC_LOW_POWER_RC_OSC) ? I_SLOW_KHZ :
		(cur_q == osp_pkg::SRC_FRC_DIV16) ? {4'h0, I_FRC_KHZ[19:4]} :
		I_FRC_KHZ;

	// pll hookup; reference follows the chosen pll source
	assign pll_if.run = cur_pll && (st_q == osp_pkg::ST_RUN);
	assign pll_if.ref_khz = (cur_q == osp_pkg::SRC_PRI_PLL) ?
		I_PRIMARY_KHZ : I_FRC_KHZ;
	assign pll_if.pre = pre_q;
	assign pll_if.post = post_q;
	assign pll_if.fbd = fbd_q;

	osp_pll #(
		.LOCK_CYC(LOCK_CYC)
	) u_pll (
		.i_clk(I_REF_CLK),
		.i_reset(I_RESET),
		.pll(pll_if.pll)
	);

	// bus address phase capture; zero wait states
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			dp_wr_q <= 1'b0;
			dp_addr_q <= 12'h000;
			rdata_q <= 32'h0;
		end
		else
		begin
			dp_wr_q <= addr_ok && I_HWRITE && word_ok;
			dp_addr_q <= a_addr;
			// unmapped or non-word reads answer zero
			rdata_q <= (addr_ok && !I_HWRITE && word_ok) ?
				{16'h0, rd_mux} : 32'h0;
		end
	end

	// unlock window: key opens it, one control write closes it
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET || I_SYS_RESET)
			unl_cnt_q <= 8'h0;
		else if (key_ok)
			unl_cnt_q <= 8'(UNL_CYC);
		else if (wr_osc || !unlocked)
			unl_cnt_q <= 8'h0;
		else
			unl_cnt_q <= unl_cnt_q - 8'h1;
	end

	// control register, loaded by power-on reset only (next source from the strap, the rest cleared)
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			// strap sampling is synchronous, so ports are safe here
			next_q <= I_INITIAL_SOURCE_CFG;
			block_q <= 1'b0;
			pin_remap_block_q <= 1'b0;
			lposc_q <= 1'b0;
		end
		else if (osc_wr)
		begin
			next_q <= wd[10:8];
			block_q <= wd[`OSP_BLOCK_BIT];
			pin_remap_block_q <= wd[`OSP_PIN_REMAP_BLOCK_BIT];
			lposc_q <= wd[`OSP_LPOSC_BIT];
		end
	end

	// flags with hardware side effects
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			cf_q <= 1'b0;
			switch_request_q <= 1'b0;
		end
		else
		begin
			cf_q <= cf_d;
			switch_request_q <= switch_request_d;
		end
	end

	// power-on straps; erased part comes up on fast rc div-n
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			cur_q <= osp_pkg::osp_src_e'(I_INITIAL_SOURCE_CFG);
			sub_q <= I_PRIMARY_SUBMODE_CFG;
			switch_monitor_cfg_q <= I_SWITCH_MONITOR_CFG;
		end
		else if (sw_done)
			cur_q <= osp_pkg::osp_src_e'(next_q);
	end

	// switch sequencer: settle, then adopt the new source
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			st_q <= osp_pkg::ST_RUN;
			sw_cnt_q <= 8'h0;
		end
		else
		begin
			unique case (st_q)
				osp_pkg::ST_RUN:
				begin
					if (sw_start)
					begin
						st_q <= osp_pkg::ST_SWITCH;
						sw_cnt_q <= 8'(SW_CYC - 1);
					end
				end
				osp_pkg::ST_SWITCH:
				begin
					if (sw_done)
						st_q <= osp_pkg::ST_RUN;
					else
						sw_cnt_q <= sw_cnt_q - 8'h1;
				end
				default:
				begin
					st_q <= osp_pkg::ST_RUN;
				end
			endcase
		end
	end

	// pll divisors; no unlock needed for these
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			post_q <= `OSP_POST_RESET;
			pre_q <= `OSP_PRE_RESET;
			fbd_q <= `OSP_FBD_RESET;
		end
		else
		begin
			if (wr_div && !post_keep)
				post_q <= wd[7:6];
			if (wr_div)
				pre_q <= wd[4:0];
			if (wr_fbd)
				fbd_q <= wd[8:0];
		end
	end

	// clock outputs; instruction clock is half the oscillator
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			fosc_q <= 20'h0;
			fcy_q <= 20'h0;
		end
		else
		begin
			fosc_q <= fosc_d;
			fcy_q <= {1'b0, fosc_d[19:1]};
		end
	end

	// outputs
	assign O_HREADYOUT = 1'b1;
	assign O_HRESP = 1'b0;
	assign O_HRDATA = rdata_q;
	assign O_PIN_REMAP_WR_EN = I_PIN_REMAP_WR && !pin_remap_block_q;
	assign O_CURRENT_SOURCE = cur_q;
	assign O_PRIMARY_SUBMODE = sub_q;
	assign O_SECONDARY_OSC_EN = lposc_q;
	assign O_PLL_LOCK = lock_rd;
	assign O_FOSC_KHZ = fosc_q;
	assign O_FCY_KHZ = fcy_q;

	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_RESET);
	fcy_half_a: assert property (
		O_FCY_KHZ == {1'b0, O_FOSC_KHZ[19:1]})
		else $error("instruction clock not half");
	blocked_hold_a: assert property (
		blocked && st_q == osp_pkg::ST_RUN |=> $stable(cur_q))
		else $error("source changed while blocked");
	remap_block_a: assert property (
		pin_remap_block_q && I_PIN_REMAP_WR |-> !O_PIN_REMAP_WR_EN)
		else $error("pin remap write let through");
	cf_set_a: assert property (I_CLOCK_FAIL && failsafe_clock_monitor_on |=> cf_q)
		else $error("clock fail lost");
	switch_end_a: assert property (
		sw_start |-> ##SW_END (st_q == osp_pkg::ST_RUN &&
		cur_q == $past(next_q)))
		else $error("switch did not finish");
	// the pll timer must have restarted once the pll left use
	locked_out_a: assert property (
		!pll_if.run |-> !O_PLL_LOCK ##1 !O_PLL_LOCK)
		else $error("lock shown off the pll");
	no_key_a: assert property (
		wr_osc && !unlocked |=> $stable(next_q) && $stable(block_q))
		else $error("locked control write took effect");
	post_rsvd_a: assert property (
		wr_div && post_keep |=> $stable(post_q))
		else $error("reserved postscale stored");
	zero_bits_a: assert property (
		addr_ok && !I_HWRITE && word_ok && a_addr == `OSP_OSC_CTRL_OFS
		|=> O_HRDATA[15] == 1'b0 && O_HRDATA[11] == 1'b0 &&
		O_HRDATA[4] == 1'b0)
		else $error("unimplemented bit read as one");
	switch_c: cover property (sw_done);
	unlock_wr_c: cover property (osc_wr);
	cf_c: cover property ($rose(cf_q));
endmodule : osp_ctrl

// ---- sim/osp_tb.sv ----
`timescale 1ns/1ps
`include "osp_regs.svh"
module testbench;
	localparam logic [15:0] KEY = 16'h5a5a; // arbitrary unlock key
	localparam int FAST_RC_OSC = 7370; // fast rc rate in khz
	localparam int PRI = 8000; // primary rate in khz
	logic clk, rst, sys_rst, hsel, hwrite, fail_in, remap_wr;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, sub_cfg, mon_cfg, pri_sub;
	logic [2:0] hsize, init_cfg, cur_src;
	logic [19:0] frc_khz, pri_khz, slow_khz, fosc, fcy;
	logic hreadyout, hresp, remap_en, sec_en, pll_lock;
	int fails, compares, cycles;
	// divisor writes, read-back and expected pll output; m = 32, then
	// m = 100 with the larger prescale keeps the vco inside its range
	logic [15:0] dv_wr [4] = '{16'h0000, 16'h0040, 16'h00c0, 16'h0083};
	logic [15:0] dv_rd [4] = '{16'h0000, 16'h0040, 16'h00c0, 16'h00c3};
	logic [15:0] fb_wr [4] = '{16'h001e, 16'h001e, 16'h001e, 16'h0062};
	int fo_exp [4] = '{FAST_RC_OSC*32/4, FAST_RC_OSC*32/8, FAST_RC_OSC*32/16, FAST_RC_OSC*100/40};
	// plain sources in turn and their expected oscillator rates
	logic [2:0] src_seq [5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h0};
	int src_exp [5] = '{PRI, 33, 33, FAST_RC_OSC / 16, FAST_RC_OSC};

	osp_ctrl #(.UNLOCK_KEY(KEY)) dut (.I_REF_CLK(clk), .I_RESET(rst),
		.I_SYS_RESET(sys_rst), .I_HSEL(hsel), .I_HADDR(haddr),
		.I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
		.I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HREADYOUT(hreadyout),
		.O_HRESP(hresp), .O_HRDATA(hrdata), .I_INITIAL_SOURCE_CFG(init_cfg),
		.I_PRIMARY_SUBMODE_CFG(sub_cfg), .I_SWITCH_MONITOR_CFG(mon_cfg),
		.I_CLOCK_FAIL(fail_in), .I_PIN_REMAP_WR(remap_wr),
		.I_FRC_KHZ(frc_khz), .I_PRIMARY_KHZ(pri_khz), .I_SLOW_KHZ(slow_khz),
		.O_PIN_REMAP_WR_EN(remap_en), .O_CURRENT_SOURCE(cur_src),
		.O_PRIMARY_SUBMODE(pri_sub), .O_SECONDARY_OSC_EN(sec_en),
		.O_PLL_LOCK(pll_lock), .O_FOSC_KHZ(fosc), .O_FCY_KHZ(fcy));

	// free-running reference clock, 40 ns period
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// hang guard: the tests need well under two thousand cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fails++;
			final_report();
		end
	end

	// verdict and end of run
	task final_report();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	// compare seen against expected, case equality keeps x from passing
	task check(input string name, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			fails++;
		end
	endtask : check

	task done(input string name);
		$display("test %s ended, fails so far %0d", name, fails);
	endtask : done

	// wait for hready high at a rising edge; global guard ends a hang
	task wait_ready();
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
	endtask : wait_ready

	// single word write: address phase, then data phase
	task bus_write(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= 1'b1;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {16'h0, d};
		wait_ready();
	endtask : bus_write

	// single word read, data taken at the edge that ends the data phase
	task bus_read(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= 1'b0;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		wait_ready();
		d = hrdata;
	endtask : bus_read

	task rd_chk(input logic [11:0] a, input logic [15:0] e, input string n);
		bus_read(a, rd);
		check(n, rd, {16'h0, e});
	endtask : rd_chk

	// control writes only land right after the key
	task unlock_wr(input logic [15:0] d);
		bus_write(`OSP_UNLOCK_OFS, KEY);
		bus_write(`OSP_OSC_CTRL_OFS, d);
	endtask : unlock_wr

	// poll until the switch request bit drops, bounded
	task wait_done();
		int n;
		n = 0;
		do
		begin
			bus_read(`OSP_OSC_CTRL_OFS, rd);
			n++;
		end while (rd[0] !== 1'b0 && n < 30);
	endtask : wait_done

	task wait_lock();
		for (int k = 0; k < 120 && pll_lock !== 1'b1; k++)
			@(posedge clk);
	endtask : wait_lock

	// power-on reset, held four cycles so the straps are captured
	task por();
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
	endtask : por

	initial
	begin
		rst = 1'b1;
		sys_rst = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		fail_in = 1'b0;
		remap_wr = 1'b0;
		init_cfg = 3'h7; // erased part
		sub_cfg = 2'h2;
		mon_cfg = 2'h1; // switching on, monitor off
		frc_khz = 20'(FAST_RC_OSC);
		pri_khz = 20'(PRI);
		slow_khz = 20'h00021;
		fails = 0;
		compares = 0;
		cycles = 0;
		por();
		// power-on state of an erased part
		rd_chk(`OSP_OSC_CTRL_OFS, 16'h7700, "ctrl");
		rd_chk(`OSP_CLK_DIV_OFS, 16'h0040, "div");
		rd_chk(`OSP_PLL_FBD_OFS, 16'h0030, "fbd");
		rd_chk(12'h010, 16'h0000, "unmapped");
		check("submode", 32'(pri_sub), 32'h2);
		check("fosc", 32'(fosc), 32'(FAST_RC_OSC));
		check("fcy", 32'(fcy), 32'(FAST_RC_OSC / 2));
		check("resp", 32'(hresp), 32'h0);
		done("power-on");
		// write without key is dropped; one key allows one write
		remap_wr <= 1'b1;
		bus_write(`OSP_OSC_CTRL_OFS, 16'h0042);
		rd_chk(`OSP_OSC_CTRL_OFS, 16'h7700, "no key");
		check("remap open", 32'(remap_en), 32'h1);
		unlock_wr(16'h8852);
		rd_chk(`OSP_OSC_CTRL_OFS, 16'h7042, "ctrl");
		check("remap shut", 32'(remap_en), 32'h0);
		check("sec en", 32'(sec_en), 32'h1);
		bus_write(`OSP_OSC_CTRL_OFS, 16'h0000);
		rd_chk(`OSP_OSC_CTRL_OFS, 16'h7042, "closed");
		done("unlock");
		// plain switch to fast rc
		unlock_wr(16'h0001);
		wait_done();
		check("ctrl", rd, 32'h0000);
		check("fosc", 32'(fosc), 32'(FAST_RC_OSC));
		check("lock off", 32'(pll_lock), 32'h0);
		done("switch");
		// fast rc with pll, then every postscale code
		bus_write(`OSP_PLL_FBD_OFS, 16'h001e);
		bus_write(`OSP_CLK_DIV_OFS, 16'h0000);
		unlock_wr(16'h0101);
		check("lock low", 32'(pll_lock), 32'h0);
		wait_done();
		wait_lock();
		rd_chk(`OSP_OSC_CTRL_OFS, 16'h1120, "locked");
		for (int i = 0; i < 4; i++)
		begin
			bus_write(`OSP_PLL_FBD_OFS, fb_wr[i]);
			bus_write(`OSP_CLK_DIV_OFS, dv_wr[i]);
			rd_chk(`OSP_CLK_DIV_OFS, dv_rd[i], "div");
			check("fosc", 32'(fosc), 32'(fo_exp[i]));
			check("fcy", 32'(fcy), 32'(fo_exp[i] / 2));
		end
		done("pll");
		// source lock holds the clock, release lets it go
		unlock_wr(16'h0081);
		repeat (30) @(posedge clk);
		check("held", 32'(cur_src), 32'h1);
		unlock_wr(16'h0001);
		wait_done();
		check("freed", 32'(cur_src), 32'h0);
		done("block");
		// each plain source but fast rc div-n in turn, ending back on fast rc
		for (int i = 0; i < 5; i++)
		begin
			unlock_wr({5'h00, src_seq[i], 8'h01});
			wait_done();
			check("src", 32'(cur_src), 32'(src_seq[i]));
			check("fosc", 32'(fosc), 32'(src_exp[i]));
		end
		done("sources");
		// other reset keeps state; power-on reloads the straps
		unlock_wr(16'h0002);
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		rd_chk(`OSP_OSC_CTRL_OFS, 16'h0002, "kept");
		init_cfg <= 3'h3;
		sub_cfg <= 2'h1;
		mon_cfg <= 2'h0; // monitor on
		por();
		check("src", 32'(cur_src), 32'h3);
		check("submode", 32'(pri_sub), 32'h1);
		wait_lock();
		rd_chk(`OSP_OSC_CTRL_OFS, 16'h3320, "ctrl");
		check("fosc", 32'(fosc), 32'(PRI * 50 / 8));
		fail_in <= 1'b1;
		@(posedge clk);
		fail_in <= 1'b0;
		bus_read(`OSP_OSC_CTRL_OFS, rd);
		check("fail set", rd & 32'h8, 32'h8);
		unlock_wr(16'h0300);
		bus_read(`OSP_OSC_CTRL_OFS, rd);
		check("fail clr", rd & 32'h8, 32'h0);
		done("resets");
		final_report();
	end
endmodule : testbench
